// file: rtc_core.sv
// real-time clock with slow clock control and calibration counter
`timescale 1ns/100ps
module rtc_core (
  input  wire logic         clk_i,      // system clock
  input  wire logic         rst_i,      // sync reset
  input  wire logic         ce_i,       // clock enable
  input  wire logic         cyc_i,      // wishbone cycle
  input  wire logic         stb_i,      // wishbone strobe
  input  wire logic         we_i,       // wishbone write
  input  wire rtc_pkg::adr_t adr_i,     // byte address
  input  wire logic [3:0]   sel_i,      // byte lanes
  input  wire rtc_pkg::word_t dat_i,    // write data
  output rtc_pkg::word_t    dat_o,      // read data
  output logic              ack_o,      // acknowledge
  input  wire logic         rc_clk_i,   // internal rc oscillator
  input  wire logic         xt_clk_i,   // crystal pin
  output logic              rc_power_o, // rc oscillator on
  output logic              xt_power_o, // crystal on
  output logic              src_sel_o,  // 1 crystal source
  output logic              filt_dis_o, // rc filter off
  output logic [1:0]        xt_bias_o,  // crystal drive
  output logic [3:0]        xt_cap_o,   // crystal load cap
  output logic [12:0]       rc_trim_o,  // rc trim value
  output logic              rtc_irq_o,  // alarm or periodic
  output logic              cal_irq_o   // capture done
);
  import rtc_pkg::*;

  // merge write data into old value per byte lane
  function automatic word_t merge(word_t o, word_t n, logic [3:0] s);
    word_t r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // synchronisers, bit 0 rc, bit 1 crystal
  logic [1:0]  s1_reg, s2_reg, s3_reg;  // three sample stages
  logic [1:0]  s1_next, s2_next, s3_next;
  logic        rcf_reg, rcf_next;       // filtered rc level
  logic        lvl_reg, lvl_next;       // last selected level
  // time counters
  logic [15:0] tick_reg, tick_next;     // slow ticks
  logic [15:0] two_reg, two_next;       // two-second units
  logic [13:0] day_reg, day_next;       // days
  logic        upd_reg, upd_next;       // counters moved
  logic [31:0] pre_reg, pre_next;       // alarm preset
  // control and status
  logic [5:0]  mode_reg, mode_next;     // alm, per, ign, psel
  logic        alm_reg, alm_next;       // alarm match flag
  logic        per_reg, per_next;       // periodic flag
  logic [3:0]  cfg_reg, cfg_next;       // filt, xt, rc, xtp
  logic [7:0]  xtune_reg, xtune_next;   // cap and bias
  logic [12:0] trim_reg, trim_next;     // rc trim
  // calibration
  logic [5:0]  ctrl_reg, ctrl_next;     // end, en, ie, total
  logic [13:0] sys_reg, sys_next;       // running count
  logic [11:0] slw_reg, slw_next;       // slow cycles seen
  logic [13:0] cval_reg, cval_next;     // captured value
  logic        done_reg, done_next;     // capture done
  logic [7:0]  ov_reg, ov_next;         // overflow tally
  // bus and interrupts
  logic        ack_reg, ack_next;
  word_t       dat_reg, dat_next;
  logic        rirq_reg, rirq_next;
  logic        cirq_reg, cirq_next;

  // decoded helpers
  idx_t        idx;                     // word index
  logic        req;                     // new bus request
  logic        wr;                      // write this cycle
  logic        lvl;                     // selected slow level
  logic        tick_ev;                 // slow rising edge
  logic        alm_en, per_en, ign;     // mode fields
  logic [2:0]  psel;                    // period select
  logic [31:0] per_mask;                // period bit mask
  logic [31:0] cmp_mask;                // alarm compare mask
  logic        per_hit, alm_hit;        // mode events
  logic        cal_en;                  // calibration running
  logic [11:0] cal_end;                 // capture length
  logic        cap;                     // capture now
  logic        ovf;                     // counter overflow

  assign idx    = adr_i[9:2];
  assign req    = cyc_i && stb_i && !ack_reg;
  assign wr     = req && we_i;
  assign alm_en = mode_reg[5];
  assign per_en = mode_reg[4];
  assign ign    = mode_reg[3];
  assign psel   = mode_reg[2:0];
  assign cal_en = ctrl_reg[4];

  // source select, filter only on the rc path
  assign lvl = cfg_reg[2] ? s2_reg[1] : (cfg_reg[3] ? s2_reg[0] : rcf_reg);

  // count only when the selected source is powered
  assign tick_ev = lvl && !lvl_reg &&
                   (cfg_reg[2] ? cfg_reg[0] : cfg_reg[1]);

  // period mask doubles per code step
  assign per_mask = (32'(PER_BASE_TICK) << psel) - 32'h1;

  // bit 0 optionally left out of the alarm match
  assign cmp_mask = ign ? 32'hffff_fffe : 32'hffff_ffff;

  // alarm checked once per counter update
  assign alm_hit = alm_en && upd_reg &&
    ((({two_reg, tick_reg} ^ pre_reg) & cmp_mask) == 32'h0);

  // capture length with optional extension
  assign cal_end = CAL_TOTAL[ctrl_reg[2:0]] +
                   (ctrl_reg[5] ? CAL_EXTRA : 12'h0);
  assign cap = cal_en && tick_ev && (slw_reg + 12'h1 >= cal_end);
  assign ovf = cal_en && !cap && (sys_reg == 14'h3fff);

  // next-state logic for the whole block
  always_comb begin
    s1_next    = {xt_clk_i, rc_clk_i};
    s2_next    = s1_reg;
    s3_next    = s2_reg;
    rcf_next   = rcf_reg;
    lvl_next   = lvl;
    tick_next  = tick_reg;
    two_next   = two_reg;
    day_next   = day_reg;
    upd_next   = tick_ev;
    pre_next   = pre_reg;
    mode_next  = mode_reg;
    alm_next   = alm_reg;
    per_next   = per_reg;
    cfg_next   = cfg_reg;
    xtune_next = xtune_reg;
    trim_next  = trim_reg;
    ctrl_next  = ctrl_reg;
    sys_next   = sys_reg;
    slw_next   = slw_reg;
    cval_next  = cval_reg;
    done_next  = done_reg;
    ov_next    = ov_reg;
    ack_next   = req;
    dat_next   = dat_reg;
    per_hit    = 1'b0;

    // noise filter takes rc level after two equal samples
    if (s2_reg[0] == s3_reg[0]) begin
      rcf_next = s3_reg[0];
    end

    // cascaded counters
    if (tick_ev) begin
      tick_next = tick_reg + 16'h1;
      if (tick_reg == 16'hffff) begin
        if (two_reg >= TWO_LAST) begin
          two_next = 16'h0;
          day_next = day_reg + 14'h1;
        end else begin
          two_next = two_reg + 16'h1;
        end
      end
      per_hit = per_en &&
        (({two_next, tick_next} & per_mask) == 32'h0);
    end

    // register writes
    if (wr) begin
      unique case (idx)
        IDX_RC_TRIM: begin
          trim_next = 13'(merge({19'h0, trim_reg}, dat_i, sel_i));
        end
        IDX_XT_TUNE: begin
          if (sel_i[0]) begin
            xtune_next = dat_i[7:0] & 8'hf3;
          end
        end
        IDX_SLOW_CFG: begin
          if (sel_i[0]) begin
            cfg_next = dat_i[3:0];
          end
        end
        IDX_FLAGS: begin
          if (sel_i[0] && alm_en && dat_i[B_CLR_ALM]) begin
            alm_next = 1'b0;
          end
          if (sel_i[0] && per_en && dat_i[B_CLR_PER]) begin
            per_next = 1'b0;
          end
        end
        IDX_MODE: begin
          if (sel_i[0]) begin
            mode_next = dat_i[5:0];
            if (dat_i[B_LOAD_HI]) begin
              day_next = pre_reg[13:0];
            end
            if (dat_i[B_LOAD_LO]) begin
              two_next  = pre_reg[31:16];
              tick_next = pre_reg[15:0];
            end
          end
        end
        IDX_PRESET: begin
          pre_next = merge(pre_reg, dat_i, sel_i);
        end
        IDX_CAL_CNT: begin
          if (sel_i[1] && dat_i[B_CAL_IF]) begin
            done_next = 1'b0;
          end
          if (sel_i[1] && dat_i[B_CAL_OV]) begin
            ov_next = 8'h0;
          end
        end
        IDX_CAL_CTRL: begin
          if (sel_i[0]) begin
            ctrl_next = {dat_i[6:4], dat_i[2:0]};
          end
        end
        default: begin
        end
      endcase
    end

    // calibration counter
    if (!cal_en) begin
      sys_next = 14'h0;
      slw_next = 12'h0;
    end else begin
      sys_next = sys_reg + 14'h1;
      if (tick_ev) begin
        slw_next = slw_reg + 12'h1;
      end
      if (cap) begin
        cval_next = sys_reg;
        sys_next  = 14'h0;
        slw_next  = 12'h0;
      end
    end

    // hardware sets win over software clears
    ov_next   = ov_next + {7'h0, ovf};
    done_next = done_next || cap;
    alm_next  = alm_next || alm_hit;
    per_next  = per_next || per_hit;

    // interrupt levels follow the flags
    rirq_next = alm_next || per_next;
    cirq_next = done_next && ctrl_next[3];

    // read data, unmapped reads return zero
    if (req) begin
      unique case (idx)
        IDX_RC_TRIM:  dat_next = {19'h0, trim_reg};
        IDX_XT_TUNE:  dat_next = {24'h0, xtune_reg};
        IDX_SLOW_CFG: dat_next = {24'h0, s2_reg[1], 3'h0, cfg_reg};
        IDX_FLAGS:    dat_next = {24'h0, alm_reg, per_reg,
                                  !alm_en, !per_en, 4'h0};
        IDX_MODE:     dat_next = {26'h0, mode_reg};
        IDX_PRESET:   dat_next = pre_reg;
        IDX_TICK:     dat_next = {16'h0, tick_reg};
        IDX_TWO:      dat_next = {16'h0, two_reg};
        IDX_DAY:      dat_next = {18'h0, day_reg};
        IDX_CAL_CNT:  dat_next = {16'h0, done_reg, ov_reg != 8'h0,
                                  cval_reg};
        IDX_CAL_OV:   dat_next = {24'h0, ov_reg};
        IDX_CAL_CTRL: dat_next = {24'h0, 1'b0, ctrl_reg[5:3],
                                  !cal_en, ctrl_reg[2:0]};
        default:      dat_next = 32'h0;
      endcase
    end
  end

  // state registers, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg    <= 2'h0;
      s2_reg    <= 2'h0;
      s3_reg    <= 2'h0;
      rcf_reg   <= 1'b0;
      lvl_reg   <= 1'b0;
      tick_reg  <= 16'h0;
      two_reg   <= 16'h0;
      day_reg   <= 14'h0;
      upd_reg   <= 1'b0;
      pre_reg   <= 32'h0;
      mode_reg  <= MODE_RST;
      alm_reg   <= 1'b0;
      per_reg   <= 1'b0;
      cfg_reg   <= CFG_RST;
      xtune_reg <= XTUNE_RST;
      trim_reg  <= TRIM_RST;
      ctrl_reg  <= CTRL_RST;
      sys_reg   <= 14'h0;
      slw_reg   <= 12'h0;
      cval_reg  <= 14'h0;
      done_reg  <= 1'b0;
      ov_reg    <= 8'h0;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0;
      rirq_reg  <= 1'b0;
      cirq_reg  <= 1'b0;
    end else if (ce_i) begin
      s1_reg    <= s1_next;
      s2_reg    <= s2_next;
      s3_reg    <= s3_next;
      rcf_reg   <= rcf_next;
      lvl_reg   <= lvl_next;
      tick_reg  <= tick_next;
      two_reg   <= two_next;
      day_reg   <= day_next;
      upd_reg   <= upd_next;
      pre_reg   <= pre_next;
      mode_reg  <= mode_next;
      alm_reg   <= alm_next;
      per_reg   <= per_next;
      cfg_reg   <= cfg_next;
      xtune_reg <= xtune_next;
      trim_reg  <= trim_next;
      ctrl_reg  <= ctrl_next;
      sys_reg   <= sys_next;
      slw_reg   <= slw_next;
      cval_reg  <= cval_next;
      done_reg  <= done_next;
      ov_reg    <= ov_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      rirq_reg  <= rirq_next;
      cirq_reg  <= cirq_next;
    end
  end

  // outputs straight from flops
  assign dat_o      = dat_reg;
  assign ack_o      = ack_reg;
  assign rc_power_o = cfg_reg[1];
  assign xt_power_o = cfg_reg[0];
  assign src_sel_o  = cfg_reg[2];
  assign filt_dis_o = cfg_reg[3];
  assign xt_bias_o  = xtune_reg[1:0];
  assign xt_cap_o   = xtune_reg[7:4];
  assign rc_trim_o  = trim_reg;
  assign rtc_irq_o  = rirq_reg;
  assign cal_irq_o  = cirq_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_mode_wr;
    ce_i && wr && idx == IDX_MODE && sel_i[0];
  endsequence

  a_alarm_match_set: assert property (
    ce_i && alm_hit |=> alm_reg && rtc_irq_o)
    else $error("alarm match did not set flag and irq");

  a_periodic_hit_set: assert property (
    ce_i && per_hit |=> per_reg && rtc_irq_o)
    else $error("periodic event lost");

  a_alarm_clear_read: assert property (
    ack_o && $past(idx) == IDX_FLAGS && $past(!we_i)
    |-> dat_o[B_CLR_ALM] == !$past(alm_en))
    else $error("alarm clear bit read wrong");

  a_load_low_copy: assert property (
    s_mode_wr ##0 dat_i[B_LOAD_LO]
    |=> {two_reg, tick_reg} == $past(pre_reg))
    else $error("load low did not copy preset");

  a_load_high_copy: assert property (
    s_mode_wr ##0 dat_i[B_LOAD_HI]
    |=> day_reg == $past(pre_reg[13:0]))
    else $error("load high did not copy preset");

  a_two_sec_wrap: assert property (
    ce_i && tick_ev && tick_reg == 16'hffff && two_reg == TWO_LAST
    && !wr |=> two_reg == 16'h0 && day_reg == $past(day_reg) + 14'h1)
    else $error("two-second wrap or day carry wrong");

  a_cal_capture_done: assert property (
    ce_i && cap |=> done_reg && cval_reg == $past(sys_reg)
    && sys_reg == 14'h0)
    else $error("capture did not complete");

  a_cal_idle_zero: assert property (
    ce_i && !cal_en ##1 ce_i && !cal_en |-> sys_reg == 14'h0)
    else $error("calibration counted while paused");

  a_ack_single: assert property (
    ack_o |=> !ack_o)
    else $error("ack held two cycles");

endmodule

// file: rtc_osc_model.sv
// slow clock sources seen by the rtc: internal rc oscillator and crystal
`timescale 1ns/100ps
module rtc_osc_model #(
  parameter int RC_HALF = 6,            // rc half period, system clocks
  parameter int XT_HALF = 7             // crystal half period, system clocks
) (
  input  wire logic clk_i,              // system clock
  input  wire logic rc_power_i,         // rc oscillator powered
  input  wire logic xt_power_i,         // crystal powered
  output logic      rc_clk_o,           // rc level
  output logic      xt_clk_o            // crystal level
);
  int rc_cnt;                           // rc half period count
  int xt_cnt;                           // crystal half period count
  // rc runs only while powered, parks low so no stray rising edge
  always @(posedge clk_i) begin
    if (rc_power_i !== 1'h1) begin
      rc_clk_o <= 1'h0;
      rc_cnt <= 0;
    end else if (rc_cnt == RC_HALF - 1) begin
      rc_clk_o <= ~rc_clk_o;
      rc_cnt <= 0;
    end else begin
      rc_cnt <= rc_cnt + 1;
    end
  end
  // crystal likewise, its own rate
  always @(posedge clk_i) begin
    if (xt_power_i !== 1'h1) begin
      xt_clk_o <= 1'h0;
      xt_cnt <= 0;
    end else if (xt_cnt == XT_HALF - 1) begin
      xt_clk_o <= ~xt_clk_o;
      xt_cnt <= 0;
    end else begin
      xt_cnt <= xt_cnt + 1;
    end
  end
endmodule

// file: rtc_pkg.sv
// package: register map, fields and constants for the real-time clock
// Function
// - alarm high half vs two-second, low vs ticks
// - full match while enabled sets alarm flag
// - ignore bit excludes preset bit 0
// - alarm clear reads 1 when disabled, w1c
// - periodic clear reads 1 when disabled, w1c
// - period select doubles from 0.125 s
// - elapsed period sets periodic flag, interrupt
// - mode bits 5 and 4 enable modes
// - load high copies preset into day counter
// - load low copies preset into both counters
// - three read-only counters 16, 16, 14 bits
// - bit 2 selects crystal or RC source
// - bits 1, 0 power RC and crystal
// - bit 3 disables RC noise filter
// - bit 7 shows synchronised pin level
// - source switch done within half period
// - bias field picks drive current, resets 11
// - calibration counts system clocks over slow cycles
// - capture done flag w1c, gated interrupt
// - overflow tally, nonzero indicator, w1c clear
// - enable, paused status, two-cycle end extend
// - 13-bit RC trim, reset 1011h
package rtc_pkg;
  typedef logic [31:0] word_t;           // bus data word
  typedef logic [9:0]  adr_t;            // bus byte address
  typedef logic [7:0]  idx_t;            // register index
  // register indices, byte address is four times these
  localparam idx_t IDX_RC_TRIM  = 8'h2c;
  localparam idx_t IDX_XT_TUNE  = 8'h2e;
  localparam idx_t IDX_SLOW_CFG = 8'h2f;
  localparam idx_t IDX_FLAGS    = 8'h30;
  localparam idx_t IDX_MODE     = 8'h31;
  localparam idx_t IDX_PRESET   = 8'h34;
  localparam idx_t IDX_TICK     = 8'h38;
  localparam idx_t IDX_TWO      = 8'h3a;
  localparam idx_t IDX_DAY      = 8'h3c;
  localparam idx_t IDX_CAL_CNT  = 8'h50;
  localparam idx_t IDX_CAL_OV   = 8'h52;
  localparam idx_t IDX_CAL_CTRL = 8'h53;
  // field positions
  localparam int B_LOAD_HI = 7;          // mode: load day
  localparam int B_LOAD_LO = 6;          // mode: load counters
  localparam int B_CLR_ALM = 5;          // flags: alarm clear
  localparam int B_CLR_PER = 4;          // flags: periodic clear
  localparam int B_CAL_IF  = 15;         // cal count: done flag
  localparam int B_CAL_OV  = 14;         // cal count: overflow
  // reset values
  localparam logic [5:0]  MODE_RST  = 6'h02;   // period 0.5 s
  localparam logic [3:0]  CFG_RST   = 4'h2;    // RC on, crystal off
  localparam logic [7:0]  XTUNE_RST = 8'hc3;   // bias 11
  localparam logic [5:0]  CTRL_RST  = 6'h01;   // two cycles
  localparam logic [12:0] TRIM_RST  = 13'h1011;
  // timing
  localparam int SLOW_HZ       = 32768;
  localparam int PER_BASE_MS   = 125;
  localparam int PER_BASE_TICK = SLOW_HZ * PER_BASE_MS / 1000;
  localparam logic [15:0] TWO_LAST  = 16'd43199;
  localparam logic [11:0] CAL_EXTRA = 12'd2;
  localparam logic [11:0] CAL_TOTAL [8] = '{12'd1, 12'd2, 12'd4,
    12'd32, 12'd64, 12'd128, 12'd1024, 12'd2047};
endpackage

// file: rtc_with_slow_clock_and_osc_calibration_tb.sv
// self-checking bench for the real-time clock core
`timescale 1ns/100ps
module rtc_with_slow_clock_and_osc_calibration_tb;
  import rtc_pkg::*;
  localparam int RC_HALF = 6;           // rc half period
  localparam int XT_HALF = 7;           // crystal half period
  localparam idx_t  RST_IX [10] = '{IDX_RC_TRIM, IDX_XT_TUNE, IDX_SLOW_CFG, IDX_FLAGS, IDX_MODE, IDX_PRESET,
    IDX_CAL_OV, IDX_CAL_CTRL, IDX_CAL_CNT, 8'h00};
  localparam word_t RST_EX [10] = '{32'h1011, 32'hc3, 32'h2, 32'h30, 32'h2, 32'h0, 32'h0, 32'h9, 32'h0, 32'h0};
  logic        clk_i;                   // system clock
  logic        rst_i;                   // sync reset
  logic        cyc_i;                   // bus cycle
  logic        stb_i;                   // bus strobe
  logic        we_i;                    // bus write
  logic [3:0]  sel_i;                   // byte lanes
  adr_t        adr_i;                   // byte address
  word_t       dat_i;                   // write data
  word_t       dat_o;                   // read data
  logic        ack_o;                   // acknowledge
  logic        rc_clk_i;                // rc level
  logic        xt_clk_i;                // crystal level
  logic        rc_power_o;              // rc powered
  logic        xt_power_o;              // crystal powered
  logic        src_sel_o;               // crystal selected
  logic        filt_dis_o;              // filter off
  logic [1:0]  xt_bias_o;               // crystal bias
  logic [3:0]  xt_cap_o;                // crystal cap
  logic [12:0] rc_trim_o;               // rc trim
  logic        rtc_irq_o;               // clock events
  logic        cal_irq_o;               // capture done
  int          n_fail;                  // mismatches
  int          compares;                // comparisons
  int          i;                       // loop index
  word_t       r;                       // random draw
  word_t       q;                       // read value
  word_t       w;                       // read value
  word_t       v;                       // preset value
  word_t       d;                       // day value

  rtc_core dut_u (.clk_i, .rst_i, .ce_i(1'h1), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .rc_clk_i, .xt_clk_i, .rc_power_o, .xt_power_o, .src_sel_o, .filt_dis_o, .xt_bias_o, .xt_cap_o,
    .rc_trim_o, .rtc_irq_o, .cal_irq_o);
  rtc_osc_model #(.RC_HALF(RC_HALF), .XT_HALF(XT_HALF)) osc_u (.clk_i, .rc_power_i(rc_power_o),
    .xt_power_i(xt_power_o), .rc_clk_o(rc_clk_i), .xt_clk_o(xt_clk_i));

  // verdict and end of run
  task automatic wrap_up();
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string nm, input word_t exp, input word_t got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic bus cycle, held until ack is sampled
  task automatic wb(input logic w1, input idx_t ix, input word_t dw, output word_t dr);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w1;
    sel_i <= 4'hf;
    adr_i <= {ix, 2'h0};
    dat_i <= dw;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'h1 && k < 40);
    dr = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    if (ack_o !== 1'h1) begin
      $display("Error ack expected 1 seen %b", ack_o);
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic wr(input idx_t ix, input word_t dw);
    word_t dr;
    wb(1'h1, ix, dw, dr);
  endtask
  task automatic rd(input idx_t ix, output word_t dr);
    wb(1'h0, ix, 32'h0, dr);
  endtask
  // read a register and compare
  task automatic rchk(input string nm, input idx_t ix, input word_t e);
    word_t dr;
    rd(ix, dr);
    chk(nm, e, dr);
  endtask
  // bounded wait for an interrupt line
  task automatic wait_irq(input logic cal, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(posedge clk_i);
      if ((cal ? cal_irq_o : rtc_irq_o) === 1'h1) return;
    end
    $display("Error %s expected 1 seen 0", cal ? "cal irq" : "rtc irq");
    n_fail++;
    wrap_up();
  endtask
  // all static control pins in one word
  function automatic word_t pins();
    return {9'h0, rc_power_o, xt_power_o, src_sel_o, filt_dis_o, xt_bias_o, xt_cap_o, rc_trim_o};
  endfunction
  // count value at which a periodic interval ends
  function automatic word_t per_end(input int p);
    return 32'h1000 << p;
  endfunction
  // captured cycles over n slow periods
  function automatic word_t cal_exp(input int n, input int half);
    return word_t'((n * 2 * half - 1) % 16384);
  endfunction
  // two captures, check the second, then stop and clear
  task automatic cal_run(input logic [2:0] c, input logic x, input word_t e, input logic ov);
    word_t dr;
    wr(IDX_CAL_CTRL, {25'h0, x, 2'h3, 1'h0, c});
    wait_irq(1'h1, 60000);
    wr(IDX_CAL_CNT, 32'h8000);
    wait_irq(1'h1, 60000);
    rd(IDX_CAL_CNT, dr);
    chk("cal value", e, {18'h0, dr[13:0]});
    chk("cal flags", {30'h0, 1'h1, ov}, {30'h0, dr[15:14]});
    rchk("cal ctrl", IDX_CAL_CTRL, {25'h0, x, 2'h3, 1'h0, c});
    wr(IDX_CAL_CTRL, {25'h0, x, 2'h1, 1'h0, c});
    rchk("cal paused", IDX_CAL_CTRL, {25'h0, x, 3'h3, c});
    wr(IDX_CAL_CNT, 32'hc000);
    rchk("cal tally", IDX_CAL_OV, 32'h0);
  endtask

  // system clock
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  // main sequence
  initial begin
    rst_i = 1'h1;
    cyc_i = 1'h0;
    stb_i = 1'h0;
    we_i = 1'h0;
    sel_i = 4'h0;
    adr_i = '0;
    dat_i = '0;
    n_fail = 0;
    compares = 0;
    r = $urandom(32'h51ec);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    // reset values, unmapped place included
    for (i = 0; i < 10; i++) rchk("reset value", RST_IX[i], RST_EX[i]);
    chk("reset pins", {9'h0, 4'h8, 2'h3, 4'hc, 13'h1011}, pins());
    // random trim and crystal tuning
    r = $urandom;
    v = $urandom;
    wr(IDX_RC_TRIM, r);
    wr(IDX_XT_TUNE, v);
    rchk("trim", IDX_RC_TRIM, {19'h0, r[12:0]});
    rchk("xt tune", IDX_XT_TUNE, {24'h0, v[7:4], 2'h0, v[1:0]});
    wr(IDX_SLOW_CFG, 32'h8);
    chk("cfg pins", {9'h0, 4'h1, v[1:0], v[7:4], r[12:0]}, pins());
    // counter loads with the oscillator parked
    d = $urandom;
    wr(IDX_PRESET, d);
    wr(IDX_MODE, 32'h82);
    rchk("day", IDX_DAY, {18'h0, d[13:0]});
    rchk("mode", IDX_MODE, 32'h2);
    v = $urandom;
    wr(IDX_PRESET, v);
    wr(IDX_MODE, 32'h42);
    rchk("tick", IDX_TICK, {16'h0, v[15:0]});
    rchk("two", IDX_TWO, {16'h0, v[31:16]});
    rchk("preset", IDX_PRESET, v);
    // every period code, then the day rollover
    for (i = 0; i <= 8; i++) begin
      v = (i == 8) ? {16'd43199, 16'hfffd} : per_end(i) - 32'h3;
      wr(IDX_PRESET, v);
      wr(IDX_MODE, 32'h50 | (i % 8));
      wr(IDX_SLOW_CFG, 32'h2);
      wait_irq(1'h0, 200);
      wr(IDX_SLOW_CFG, 32'h0);
      rd(IDX_TWO, q);
      rd(IDX_TICK, w);
      chk("periodic end", (i == 8) ? 32'h0 : per_end(i), {q[15:0], w[15:0]});
      rchk("periodic flags", IDX_FLAGS, 32'h60);
      wr(IDX_FLAGS, 32'h10);
      rchk("periodic cleared", IDX_FLAGS, 32'h20);
    end
    rchk("day carry", IDX_DAY, {18'h0, d[13:0] + 14'h1});
    // alarm with and without the lowest bit ignored
    for (i = 0; i < 2; i++) begin
      wr(IDX_PRESET, 32'h30000);
      wr(IDX_MODE, i ? 32'h60 : 32'h68);
      wr(IDX_PRESET, 32'h30005);
      wr(IDX_SLOW_CFG, 32'h2);
      wait_irq(1'h0, 200);
      wr(IDX_SLOW_CFG, 32'h0);
      rchk("alarm tick", IDX_TICK, i ? 32'h5 : 32'h4);
      rchk("alarm two", IDX_TWO, 32'h3);
      rchk("alarm flags", IDX_FLAGS, 32'h90);
      wr(IDX_FLAGS, 32'h20);
      rchk("alarm cleared", IDX_FLAGS, 32'h10);
    end
    wr(IDX_MODE, 32'h2);
    // calibration on the rc source
    wr(IDX_SLOW_CFG, 32'h2);
    cal_run(3'h0, 1'h0, cal_exp(1, RC_HALF), 1'h0);
    cal_run(3'h2, 1'h1, cal_exp(6, RC_HALF), 1'h0);
    cal_run(3'h3, 1'h0, cal_exp(32, RC_HALF), 1'h0);
    cal_run(3'h7, 1'h0, cal_exp(2047, RC_HALF), 1'h1);
    // move to the crystal: full bias, power, settle, rated bias, select
    wr(IDX_XT_TUNE, 32'hc3);
    wr(IDX_SLOW_CFG, 32'h3);
    repeat (200) @(posedge clk_i);
    wr(IDX_XT_TUNE, 32'hc1);
    wr(IDX_SLOW_CFG, 32'h7);
    repeat (16) @(posedge clk_i);
    chk("xt pins", {9'h0, 4'he, 2'h1, 4'hc, r[12:0]}, pins());
    cal_run(3'h0, 1'h0, cal_exp(1, XT_HALF), 1'h0);
    wrap_up();
  end
endmodule
